// ---- rtl/stream_priority_msg_pkg.sv ----
// shared constants, types and helpers for the stream and priority-message ends
package stream_priority_msg_pkg;

    // datapath: one 4-byte lane word per user clock
    localparam int DATA_W = 32;
    localparam int KEEP_W = 4;
    localparam int SIZE_W = 3;
    localparam int CNT_W = 3;
    localparam int MSG_W = 128;
    localparam int BEAT_BYTES = 4;

    // clock and clock-compensation timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int CC_BYTES_PER_LANE = 10000;
    localparam int CC_PERIOD_CLK = CC_BYTES_PER_LANE / BEAT_BYTES;
    localparam int CC_TIMER_W = 12;
    localparam logic [CC_TIMER_W-1:0] CC_TIMER_LAST =
        CC_TIMER_W'(CC_PERIOD_CLK - 1);
    localparam logic [CC_TIMER_W-1:0] CC_TIMER_ZERO = 12'h000;
    localparam logic [CC_TIMER_W-1:0] CC_TIMER_STEP = 12'h001;
    localparam logic [CNT_W-1:0] CC_HOLD_LAST = 3'h2;

    // small counter and keep constants
    localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
    localparam logic [CNT_W-1:0] CNT_STEP = 3'h1;
    localparam logic [KEEP_W-1:0] KEEP_ALL = 4'hF;
    localparam logic [KEEP_W-1:0] KEEP_HI2 = 4'hC;
    localparam logic [KEEP_W-1:0] KEEP_NONE = 4'h0;
    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
    localparam logic [SIZE_W-1:0] SIZE_ZERO = 3'h0;
    localparam logic [MSG_W-1:0] MSG_ZERO = 128'h0;

    // what a lane word carries on the serial side
    typedef enum logic [2:0]
    {
        LANE_IDLE,
        LANE_DATA,
        LANE_UFC_HDR,
        LANE_UFC_DATA,
        LANE_CC
    } lane_kind_t;

    // size code = bytes/2 - 1; beats on a 4-byte bus = code/2 + 1
    function automatic logic [CNT_W-1:0] last_beat_of(
        input logic [SIZE_W-1:0] size);
        last_beat_of = {1'b0, size[SIZE_W-1:1]};
    endfunction

    // odd codes fill the last beat, even codes use its upper two bytes
    function automatic logic [KEEP_W-1:0] keep_of(
        input logic [SIZE_W-1:0] size);
        keep_of = size[0] ? KEEP_ALL : KEEP_HI2;
    endfunction

endpackage

// ---- rtl/stream_priority_msg_if.sv ----
// interface joining the link core end and the user application end
`timescale 1ns/1ps
`default_nettype none

interface stream_priority_msg_if;
    import stream_priority_msg_pkg::*;

    // streaming transmit, user to core
    logic tx_tvalid;
    logic tx_tready;
    logic [DATA_W-1:0] tx_tdata;
    // streaming receive, core to user, no backpressure
    logic rx_tvalid;
    logic [DATA_W-1:0] rx_tdata;
    // priority-message request
    logic ufc_tx_tvalid;
    logic ufc_tx_tready;
    logic [SIZE_W-1:0] ufc_tx_tdata;
    // priority-message receive stream
    logic ufc_rx_tvalid;
    logic ufc_rx_tlast;
    logic [DATA_W-1:0] ufc_rx_tdata;
    logic [KEEP_W-1:0] ufc_rx_tkeep;

    modport device_mp
    (
        input tx_tvalid, tx_tdata, ufc_tx_tvalid, ufc_tx_tdata,
        output tx_tready, rx_tvalid, rx_tdata, ufc_tx_tready,
        output ufc_rx_tvalid, ufc_rx_tlast, ufc_rx_tdata, ufc_rx_tkeep
    );

    modport user_mp
    (
        output tx_tvalid, tx_tdata, ufc_tx_tvalid, ufc_tx_tdata,
        input tx_tready, rx_tvalid, rx_tdata, ufc_tx_tready,
        input ufc_rx_tvalid, ufc_rx_tlast, ufc_rx_tdata, ufc_rx_tkeep
    );

endinterface

`default_nettype wire

// ---- rtl/stream_priority_msg_device.sv ----
// link core end: streaming pipe, clock compensation, priority messages
// Functional notes
// - tx ready stays high except during compensation and message transfer
// - user valid gaps become idle lane words
// - user must capture every received word immediately
// - word moves only when valid and ready
// - message ports exist only when option enabled; here they always exist and are held low when the option is off
// - message request uses handshake plus 3-bit size
// - message length even, two to sixteen bytes
// - user holds request and size until ready
// - payload on tx data after request ready
// - tx ready low while payload uses bus
// - user waits for completion before next request
// - user starts message only with whole payload
// - accepted message runs to completion without pause
// - four-byte message opens two-cycle ready gap
// - narrow bus sends header then one beat each
// - received messages leave with valid, last, keep
// - four-byte message gives valid, last, full keep
// - eight-byte message is two beats, full keep
// - simplex builds keep only their direction's ports; here all ports remain, disabled user outputs are held low, lane tx still sends compensation
// - compensation suspends user transfers three cycles
// - compensation recurs every 2,500 user clocks
`timescale 1ns/1ps
`default_nettype none

module stream_priority_msg_device
    import stream_priority_msg_pkg::*;
#(
    parameter bit UFC_ENABLE = 1'b1,
    parameter bit TX_ENABLE = 1'b1,
    parameter bit RX_ENABLE = 1'b1
)
(
    input wire logic CORE_CLK_I,
    input wire logic ARST_N_I,
    input wire logic CE_I,
    input wire logic CHANNEL_UP_I,
    stream_priority_msg_if.device_mp user_port,
    input wire logic [DATA_W-1:0] LANE_RX_DATA_I,
    input wire lane_kind_t LANE_RX_KIND_I,
    output logic [DATA_W-1:0] LANE_TX_DATA_O,
    output lane_kind_t LANE_TX_KIND_O
);

    ////////////////////////////////////////////////////////////////////////
    // transmit sequencer state
    typedef enum logic [1:0]
    {
        TX_RUN,
        TX_UFC_HDR,
        TX_UFC_PAY,
        TX_CC
    } tx_state_t;

    tx_state_t state_ff;
    tx_state_t nxt_state;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic [CC_TIMER_W-1:0] cc_timer_ff;
    logic [CC_TIMER_W-1:0] nxt_cc_timer;
    logic cc_pend_ff;
    logic nxt_cc_pend;
    logic tx_ready_ff;
    logic nxt_tx_ready;
    logic ufc_ready_ff;
    logic nxt_ufc_ready;
    logic [DATA_W-1:0] nxt_lane_data;
    lane_kind_t nxt_lane_kind;

    // simplex and option gating of each path
    wire tx_on = TX_ENABLE;
    wire ufc_tx_on = UFC_ENABLE && TX_ENABLE;
    wire ufc_rx_on = UFC_ENABLE && RX_ENABLE;

    // word transfer and message request decode
    wire word_xfer = user_port.tx_tvalid && tx_ready_ff;
    wire ufc_want = ufc_tx_on && user_port.ufc_tx_tvalid;
    wire ufc_take = ufc_want && ufc_ready_ff;
    wire cc_due = CHANNEL_UP_I && (cc_timer_ff == CC_TIMER_LAST);
    wire cnt_done = (cnt_ff == CNT_ZERO);
    wire [CNT_W-1:0] cnt_dec = cnt_ff - CNT_STEP;
    wire [CC_TIMER_W-1:0] timer_inc = cc_timer_ff + CC_TIMER_STEP;

    ////////////////////////////////////////////////////////////////////////
    // compensation timer: free running while the channel is up
    // a due tick in the same cycle as the pending clear keeps the flag set
    assign nxt_cc_timer = (cc_due || !CHANNEL_UP_I) ? CC_TIMER_ZERO :
        timer_inc;
    assign nxt_cc_pend = CHANNEL_UP_I &&
        (cc_due || (cc_pend_ff && state_ff != TX_RUN));

    ////////////////////////////////////////////////////////////////////////
    // sequencer: compensation is deferred while a message is in flight,
    // so an accepted message never stalls mid-way

    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_lane_data = DATA_ZERO;
        nxt_lane_kind = LANE_IDLE;
        case (state_ff)
            TX_RUN:
            begin
                if (word_xfer)
                begin
                    nxt_lane_kind = LANE_DATA;
                    nxt_lane_data = user_port.tx_tdata;
                end
                if (cc_pend_ff)
                begin
                    nxt_state = TX_CC;
                    nxt_cnt = CC_HOLD_LAST;
                end
                else if (ufc_want && CHANNEL_UP_I)
                begin
                    nxt_state = TX_UFC_HDR;
                end
            end
            TX_UFC_HDR:
            begin
                if (ufc_take)
                begin
                    // header is loaded in the request-ready cycle and is on the lane in the cycle after
                    nxt_state = TX_UFC_PAY;
                    nxt_cnt = last_beat_of(user_port.ufc_tx_tdata);
                    nxt_lane_kind = LANE_UFC_HDR;
                    nxt_lane_data = {{(DATA_W-SIZE_W){1'b0}},
                        user_port.ufc_tx_tdata};
                end
                else
                begin
                    nxt_state = TX_RUN;
                end
            end
            TX_UFC_PAY:
            begin
                // payload taken every cycle, tx valid is not consulted
                nxt_lane_kind = LANE_UFC_DATA;
                nxt_lane_data = user_port.tx_tdata;
                nxt_cnt = cnt_dec;
                if (cnt_done)
                begin
                    nxt_state = TX_RUN;
                end
            end
            TX_CC:
            begin
                nxt_lane_kind = LANE_CC;
                nxt_cnt = cnt_dec;
                if (cnt_done)
                begin
                    nxt_state = TX_RUN;
                end
            end
            default:
            begin
                nxt_state = TX_RUN;
            end
        endcase
        if (!CHANNEL_UP_I)
        begin
            nxt_state = TX_RUN;
            nxt_lane_kind = LANE_IDLE;
        end
    end

    // ready flags follow the state being entered
    assign nxt_tx_ready = tx_on && CHANNEL_UP_I &&
        (nxt_state == TX_RUN);
    assign nxt_ufc_ready = (nxt_state == TX_UFC_HDR);

    ////////////////////////////////////////////////////////////////////////
    // transmit registers
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            state_ff <= TX_RUN;
            cnt_ff <= CNT_ZERO;
            cc_timer_ff <= CC_TIMER_ZERO;
            cc_pend_ff <= 1'b0;
            tx_ready_ff <= 1'b0;
            ufc_ready_ff <= 1'b0;
            LANE_TX_DATA_O <= DATA_ZERO;
            LANE_TX_KIND_O <= LANE_IDLE;
        end
        else if (CE_I)
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            cc_timer_ff <= nxt_cc_timer;
            cc_pend_ff <= nxt_cc_pend;
            tx_ready_ff <= nxt_tx_ready;
            ufc_ready_ff <= nxt_ufc_ready;
            LANE_TX_DATA_O <= nxt_lane_data;
            LANE_TX_KIND_O <= nxt_lane_kind;
        end
    end

    assign user_port.tx_tready = tx_ready_ff;
    assign user_port.ufc_tx_tready = ufc_ready_ff;

    ////////////////////////////////////////////////////////////////////////
    // receive side: words are presented once, there is no holding buffer
    logic rx_valid_ff;
    logic [DATA_W-1:0] rx_data_ff;
    logic rx_busy_ff;
    logic [CNT_W-1:0] rx_cnt_ff;
    logic [SIZE_W-1:0] rx_size_ff;
    logic urx_valid_ff;
    logic urx_last_ff;
    logic [DATA_W-1:0] urx_data_ff;
    logic [KEEP_W-1:0] urx_keep_ff;

    wire rx_word = RX_ENABLE && (LANE_RX_KIND_I == LANE_DATA);
    wire rx_hdr = ufc_rx_on && (LANE_RX_KIND_I == LANE_UFC_HDR);
    wire rx_pay = ufc_rx_on && rx_busy_ff &&
        (LANE_RX_KIND_I == LANE_UFC_DATA);
    wire rx_end = rx_pay && (rx_cnt_ff == CNT_ZERO);
    wire [SIZE_W-1:0] hdr_size = LANE_RX_DATA_I[SIZE_W-1:0];
    wire [CNT_W-1:0] rx_cnt_dec = rx_cnt_ff - CNT_STEP;
    wire [KEEP_W-1:0] end_keep = keep_of(rx_size_ff);

    // message framing: valid on each payload beat, last and keep at end
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            rx_valid_ff <= 1'b0;
            rx_data_ff <= DATA_ZERO;
            rx_busy_ff <= 1'b0;
            rx_cnt_ff <= CNT_ZERO;
            rx_size_ff <= SIZE_ZERO;
            urx_valid_ff <= 1'b0;
            urx_last_ff <= 1'b0;
            urx_data_ff <= DATA_ZERO;
            urx_keep_ff <= KEEP_NONE;
        end
        else if (CE_I)
        begin
            rx_valid_ff <= rx_word;
            rx_data_ff <= rx_word ? LANE_RX_DATA_I : rx_data_ff;
            if (rx_hdr)
            begin
                rx_busy_ff <= 1'b1;
                rx_size_ff <= hdr_size;
                rx_cnt_ff <= last_beat_of(hdr_size);
            end
            else if (rx_pay)
            begin
                rx_busy_ff <= !rx_end;
                rx_cnt_ff <= rx_cnt_dec;
            end
            urx_valid_ff <= rx_pay;
            urx_last_ff <= rx_end;
            urx_data_ff <= rx_pay ? LANE_RX_DATA_I : urx_data_ff;
            urx_keep_ff <= rx_end ? end_keep : KEEP_NONE;
        end
    end

    assign user_port.rx_tvalid = rx_valid_ff;
    assign user_port.rx_tdata = rx_data_ff;
    assign user_port.ufc_rx_tvalid = urx_valid_ff;
    assign user_port.ufc_rx_tlast = urx_last_ff;
    assign user_port.ufc_rx_tdata = urx_data_ff;
    assign user_port.ufc_rx_tkeep = urx_keep_ff;

endmodule

`default_nettype wire

// ---- rtl/stream_priority_msg_user.sv ----
// user application end: word source, message sender, receive capture
`timescale 1ns/1ps
`default_nettype none

module stream_priority_msg_user
    import stream_priority_msg_pkg::*;
(
    input wire logic CORE_CLK_I,
    input wire logic ARST_N_I,
    input wire logic CE_I,
    stream_priority_msg_if.user_mp core_port,
    input wire logic WORD_VALID_I,
    input wire logic [DATA_W-1:0] WORD_DATA_I,
    output logic WORD_READY_O,
    input wire logic MSG_START_I,
    input wire logic [SIZE_W-1:0] MSG_SIZE_I,
    input wire logic [MSG_W-1:0] MSG_DATA_I,
    output logic MSG_IDLE_O,
    output logic RX_WORD_VALID_O,
    output logic [DATA_W-1:0] RX_WORD_DATA_O,
    output logic RX_MSG_VALID_O,
    output logic RX_MSG_LAST_O,
    output logic [DATA_W-1:0] RX_MSG_DATA_O,
    output logic [KEEP_W-1:0] RX_MSG_KEEP_O
);

    typedef enum logic [1:0]
    {
        MS_IDLE,
        MS_REQ,
        MS_PAY
    } msg_state_t;

    msg_state_t ms_ff;
    msg_state_t nxt_ms;
    logic tvalid_ff;
    logic [DATA_W-1:0] tdata_ff;
    logic [MSG_W-1:0] msg_ff;
    logic [SIZE_W-1:0] size_ff;
    logic [CNT_W-1:0] beat_ff;

    wire word_done = tvalid_ff && core_port.tx_tready;
    wire word_load = WORD_VALID_I && WORD_READY_O;
    wire msg_load = MSG_START_I && MSG_IDLE_O;
    wire req_take = (ms_ff == MS_REQ) && core_port.ufc_tx_tready;
    wire beat_last = (beat_ff == CNT_ZERO);
    wire hold_word = tvalid_ff && !word_done;
    wire [DATA_W-1:0] msg_head = msg_ff[MSG_W-1 -: DATA_W];
    wire [MSG_W-1:0] msg_shift = {msg_ff[MSG_W-DATA_W-1:0], DATA_ZERO};
    wire [CNT_W-1:0] beat_dec = beat_ff - CNT_STEP;

    // message sequence: request held until ready, then payload beats
    always_comb
    begin
        nxt_ms = ms_ff;
        case (ms_ff)
            MS_IDLE:
            begin
                if (msg_load)
                begin
                    nxt_ms = MS_REQ;
                end
            end
            MS_REQ:
            begin
                if (req_take)
                begin
                    nxt_ms = MS_PAY;
                end
            end
            MS_PAY:
            begin
                if (beat_last)
                begin
                    nxt_ms = MS_IDLE;
                end
            end
            default:
            begin
                nxt_ms = MS_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit registers; a message only starts with no word pending,
    // so the data bus is free for payload

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            ms_ff <= MS_IDLE;
            tvalid_ff <= 1'b0;
            tdata_ff <= DATA_ZERO;
            msg_ff <= MSG_ZERO;
            size_ff <= SIZE_ZERO;
            beat_ff <= CNT_ZERO;
            WORD_READY_O <= 1'b0;
            MSG_IDLE_O <= 1'b0;
        end
        else if (CE_I)
        begin
            ms_ff <= nxt_ms;
            tvalid_ff <= word_load || hold_word;
            WORD_READY_O <= !word_load && !hold_word && !msg_load &&
                (nxt_ms == MS_IDLE);
            MSG_IDLE_O <= !word_load && !hold_word && (nxt_ms == MS_IDLE);
            if (msg_load)
            begin
                msg_ff <= MSG_DATA_I;
                size_ff <= MSG_SIZE_I;
                beat_ff <= last_beat_of(MSG_SIZE_I);
            end
            if (word_load)
            begin
                tdata_ff <= WORD_DATA_I;
            end
            else if (req_take || (ms_ff == MS_PAY))
            begin
                // first beat on the bus in the cycle after request ready
                tdata_ff <= msg_head;
                msg_ff <= msg_shift;
            end
            if (ms_ff == MS_PAY)
            begin
                beat_ff <= beat_dec;
            end
        end
    end

    assign core_port.tx_tvalid = tvalid_ff;
    assign core_port.tx_tdata = tdata_ff;
    assign core_port.ufc_tx_tvalid = (ms_ff == MS_REQ);
    assign core_port.ufc_tx_tdata = size_ff;

    ////////////////////////////////////////////////////////////////////////
    // receive capture: every presented word is registered at once

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            RX_WORD_VALID_O <= 1'b0;
            RX_WORD_DATA_O <= DATA_ZERO;
            RX_MSG_VALID_O <= 1'b0;
            RX_MSG_LAST_O <= 1'b0;
            RX_MSG_DATA_O <= DATA_ZERO;
            RX_MSG_KEEP_O <= KEEP_NONE;
        end
        else if (CE_I)
        begin
            RX_WORD_VALID_O <= core_port.rx_tvalid;
            RX_WORD_DATA_O <= core_port.rx_tdata;
            RX_MSG_VALID_O <= core_port.ufc_rx_tvalid;
            RX_MSG_LAST_O <= core_port.ufc_rx_tlast;
            RX_MSG_DATA_O <= core_port.ufc_rx_tdata;
            RX_MSG_KEEP_O <= core_port.ufc_rx_tkeep;
        end
    end

endmodule

`default_nettype wire

// ---- testbench/stream_priority_msg_asserts.sv ----
// concurrent checks on the signals between the two ends
`timescale 1ns/1ps
`default_nettype none

module stream_priority_msg_asserts
    import stream_priority_msg_pkg::*;
(
    input wire logic CORE_CLK_I,
    input wire logic ARST_N_I,
    input wire logic tx_tvalid,
    input wire logic tx_tready,
    input wire logic [DATA_W-1:0] tx_tdata,
    input wire logic ufc_tx_tvalid,
    input wire logic ufc_tx_tready,
    input wire logic [SIZE_W-1:0] ufc_tx_tdata,
    input wire logic ufc_rx_tvalid,
    input wire logic ufc_rx_tlast,
    input wire logic [KEEP_W-1:0] ufc_rx_tkeep
);
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!ARST_N_I);

    ////////////////////////////////////////////////////////////////////////
    // payload beats still owed, and length of the current ready-low run
    logic [CNT_W-1:0] left_ff;
    logic [3:0] low_ff;
    wire logic busy = ufc_tx_tready || (left_ff != CNT_ZERO);
    wire logic [CNT_W-1:0] nxt_left = ufc_tx_tready ?
        {1'b0, ufc_tx_tdata[2:1]} + CNT_STEP :
        (left_ff != CNT_ZERO) ? left_ff - CNT_STEP : CNT_ZERO;
    // saturate so a stuck ready cannot wrap back to a legal count
    wire logic [3:0] nxt_low = tx_tready ? 4'h0 :
        (low_ff == 4'hF) ? low_ff : low_ff + 4'h1;

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            left_ff <= CNT_ZERO;
            low_ff <= 4'h0;
        end
        else
        begin
            left_ff <= nxt_left;
            low_ff <= nxt_low;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // loopback frame timing: header, payload, then one-cycle rx latency
    sequence s_taken(logic [SIZE_W-1:0] code);
        ufc_tx_tvalid && ufc_tx_tready && ufc_tx_tdata == code;
    endsequence
    sequence s_frame_end;
        ufc_rx_tvalid && ufc_rx_tlast && ufc_rx_tkeep == KEEP_ALL;
    endsequence

    a_msg_blocks_tx: assert property (busy |-> !tx_tready)
        else $error("tx ready high while message owns the bus");
    a_req_ready_pulse: assert property (ufc_tx_tready |=> !ufc_tx_tready)
        else $error("message ready longer than one cycle");
    a_short_gap: assert property (s_taken(3'h1) |-> !tx_tready[*2])
        else $error("four-byte message gap too short");
    a_ready_stays: assert property (low_ff < 4'hC)
        else $error("tx ready low too long");
    a_req_held: assert property (ufc_tx_tvalid && !ufc_tx_tready |=>
        ufc_tx_tvalid && $stable(ufc_tx_tdata))
        else $error("message request dropped or changed");
    a_word_held: assert property (tx_tvalid && !tx_tready && !busy |=>
        tx_tvalid && $stable(tx_tdata))
        else $error("tx word dropped or changed before ready");
    a_last_keep: assert property (ufc_rx_tlast |-> ufc_rx_tvalid &&
        (ufc_rx_tkeep == KEEP_ALL || ufc_rx_tkeep == KEEP_HI2))
        else $error("bad last beat of received message");
    a_mid_keep: assert property (ufc_rx_tvalid && !ufc_rx_tlast |->
        ufc_rx_tkeep == KEEP_NONE)
        else $error("keep set on a middle beat");
    a_one_beat: assert property (s_taken(3'h1) |-> ##3 s_frame_end)
        else $error("one-beat message frame wrong");
    a_two_beat: assert property (s_taken(3'h3) |-> ##3
        (ufc_rx_tvalid && !ufc_rx_tlast) ##1 s_frame_end)
        else $error("two-beat message frame wrong");
endmodule

`default_nettype wire

// ---- testbench/testbench.sv ----
// loopback bench: both ends joined, lane output fed back to lane input
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, gt) \
    begin \
        cmp_count++; \
        if ((gt) !== (ex)) \
        begin \
            $display("CHECK FAILED %s exp %0h got %0h", nm, ex, gt); \
            mismatches++; \
        end \
    end

module testbench
    import stream_priority_msg_pkg::*;
;
    typedef struct packed {logic [31:0] d; logic l; logic [3:0] k;} beat_t;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic chan_up = 1'b0;
    logic wvalid = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic mstart = 1'b0;
    logic [2:0] msize = 3'h0;
    logic [127:0] mdata = 128'h0;
    logic wready, midle, rxw_v, rxm_v, rxm_l;
    logic [31:0] rxw_d, rxm_d;
    logic [3:0] rxm_k;
    wire logic [31:0] lane_data;
    wire lane_kind_t lane_kind;
    int mismatches = 0;
    int cmp_count = 0;
    int cyc = 0;
    int cc_run = 0;
    int cc_last = 0;
    bit msg_seen = 1'b0;
    bit take_q = 1'b0;
    logic [31:0] exp_w[$];
    beat_t exp_m[$];
    beat_t b;
    logic [31:0] w_exp, msk;

    stream_priority_msg_if ifc();

    stream_priority_msg_device stream_priority_msg_device_i (
        .CORE_CLK_I(core_clk), .ARST_N_I(arst_n), .CE_I(1'b1),
        .CHANNEL_UP_I(chan_up), .user_port(ifc),
        .LANE_RX_DATA_I(lane_data), .LANE_RX_KIND_I(lane_kind),
        .LANE_TX_DATA_O(lane_data), .LANE_TX_KIND_O(lane_kind));

    stream_priority_msg_user stream_priority_msg_user_i (
        .CORE_CLK_I(core_clk), .ARST_N_I(arst_n), .CE_I(1'b1),
        .core_port(ifc), .WORD_VALID_I(wvalid), .WORD_DATA_I(wdata),
        .WORD_READY_O(wready), .MSG_START_I(mstart), .MSG_SIZE_I(msize),
        .MSG_DATA_I(mdata), .MSG_IDLE_O(midle), .RX_WORD_VALID_O(rxw_v),
        .RX_WORD_DATA_O(rxw_d), .RX_MSG_VALID_O(rxm_v),
        .RX_MSG_LAST_O(rxm_l), .RX_MSG_DATA_O(rxm_d),
        .RX_MSG_KEEP_O(rxm_k));

    stream_priority_msg_asserts stream_priority_msg_asserts_i (
        .CORE_CLK_I(core_clk), .ARST_N_I(arst_n),
        .tx_tvalid(ifc.tx_tvalid), .tx_tready(ifc.tx_tready),
        .tx_tdata(ifc.tx_tdata), .ufc_tx_tvalid(ifc.ufc_tx_tvalid),
        .ufc_tx_tready(ifc.ufc_tx_tready), .ufc_tx_tdata(ifc.ufc_tx_tdata),
        .ufc_rx_tvalid(ifc.ufc_rx_tvalid), .ufc_rx_tlast(ifc.ufc_rx_tlast),
        .ufc_rx_tkeep(ifc.ufc_rx_tkeep));

    ////////////////////////////////////////////////////////////////////////
    // clock, 10 ns period
    initial
    begin
        forever #5 core_clk = ~core_clk;
    end

    // odd size codes fill the last beat, even ones only its upper half
    function automatic logic [3:0] exp_keep(logic [2:0] c, bit last);
        exp_keep = !last ? 4'h0 : (c[0] ? 4'hF : 4'hC);
    endfunction

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // one cycle of word traffic; pv is the percent chance of valid
    task automatic step(input int pv);
        @(posedge core_clk);
        #1;
        wvalid = ($urandom_range(99) < pv);
        wdata = $urandom();
        mstart = 1'b0;
    endtask

    // send one message, then wait until its frame has come back
    task automatic send_msg(input logic [2:0] code);
        int n;
        n = 0;
        while (midle !== 1'b1 && n < 200)
        begin
            step(50);
            n++;
        end
        mstart = 1'b1;
        msize = code;
        mdata = {$urandom(), $urandom(), $urandom(), $urandom()};
        step(50);
        while (exp_m.size() != 0 && n < 200)
        begin
            step(50);
            n++;
        end
        if (n >= 200)
        begin
            mismatches++;
            give_verdict();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // scoreboard: expectations pushed at acceptance, popped on receipt
    always @(posedge core_clk)
    begin
        if (arst_n)
        begin
            cyc++;
            `CHK("lane data kind", take_q, lane_kind == LANE_DATA);
            take_q = ifc.tx_tvalid && ifc.tx_tready;
            if (wvalid && wready)
                exp_w.push_back(wdata);
            if (mstart && midle)
            begin
                msg_seen = 1'b1;
                for (int k = 0; k <= msize / 2; k++)
                begin
                    b.d = mdata[127 - 32 * k -: 32];
                    b.l = (k == msize / 2);
                    b.k = exp_keep(msize, b.l);
                    exp_m.push_back(b);
                end
            end
            if (rxw_v && exp_w.size() != 0)
            begin
                w_exp = exp_w.pop_front();
                `CHK("rx word", w_exp, rxw_d);
            end
            else if (rxw_v)
                `CHK("rx word unexpected", 1'b0, rxw_v);
            if (rxm_v && exp_m.size() != 0)
            begin
                b = exp_m.pop_front();
                `CHK("msg last", b.l, rxm_l);
                `CHK("msg keep", b.k, rxm_k);
                msk = {{16{1'b1}}, {16{b.k != 4'hC}}};
                `CHK("msg data", b.d & msk, rxm_d & msk);
            end
            else if (rxm_v)
                `CHK("msg unexpected", 1'b0, rxm_v);
            if (lane_kind == LANE_CC && cc_run == 0)
            begin
                if (cc_last != 0 && !msg_seen)
                    `CHK("cc period", CC_PERIOD_CLK, cyc - cc_last);
                cc_last = cyc;
                msg_seen = 1'b0;
            end
            if (lane_kind == LANE_CC)
                cc_run++;
            else if (cc_run != 0)
            begin
                `CHK("cc length", 3, cc_run);
                cc_run = 0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // main sequence: reset, mixed words and messages, long stream, drain
    initial
    begin
        void'($urandom(11802));
        repeat (5) @(posedge core_clk);
        #1;
        arst_n = 1'b1;
        chan_up = 1'b1;
        repeat (2) step(0);
        // every size code twice, then random ones, words in between
        for (int i = 0; i < 24; i++)
        begin
            repeat ($urandom_range(20, 1)) step(60);
            send_msg(i < 16 ? i[2:0] : 3'($urandom_range(7)));
        end
        // long stream so compensation recurs with no message nearby
        repeat (5600) step(90);
        wvalid = 1'b0;
        for (int n = 0; n < 60 && exp_w.size() != 0; n++)
            step(0);
        `CHK("words drained", 0, exp_w.size());
        `CHK("msgs drained", 0, exp_m.size());
        give_verdict();
    end
endmodule

`default_nettype wire
